// file: design/pel_top.v
// per-port error detect masks, first/next error logs and report steering
`timescale 1ns/1ps
`default_nettype none
`include "pel_regs.vh"

// Contract
// RULE1: a masked uncorrectable error is neither reported nor logged anywhere.
// RULE2: uncorrectable mask bits 20,18,17,16,15,14,13,12 cover transaction errors.
// RULE3: uncorrectable mask bits 5,4,0 cover link down, link protocol, training.
// RULE4: port-0 variant adds bit 21 for host reset timeout; else reserved.
// RULE5: correctable mask bits 13,12,8,7,6,0; all detected unless masked.
// RULE6: root message mask bits 2 fatal, 1 uncorrectable, 0 correctable.
// RULE7: first-fatal log captures only while empty, then locks.
// RULE8: first non-fatal/correctable log locks after its first capture.
// RULE9: later fatal errors go to the next-fatal log.
// RULE10: next-fatal log is written only while first-fatal holds bits.
// RULE11: severity input sorts uncorrectable errors into fatal or non-fatal.
// RULE12: first-fatal bits 12 down to 4 as laid out in the table.
// RULE13: first-fatal bits 3 training, 2 UR, 1 fatal message, 0 link.
// RULE14: next-fatal log uses the first-fatal bit layout.
// RULE15: non-fatal/correctable log bits 17 down to 10 per table.
// RULE16: non-fatal/correctable bits 9,8,5,4,2,0; bits 7,6,3,1 stay zero.
// RULE17: advisory non-fatal errors are kept out of the non-fatal log.
// RULE18: advisory errors still reach the steered report outputs.
// RULE19: software uses link training status, not the training bits.
// RULE20: 2-bit steering: 00,01,10 error pins, 11 machine check.
// RULE21: logs clear on cold reset or write-one, survive warm reset.
module pel_top #(
  parameter HOST_PORT = 0,
  parameter AW        = 12
) (
  input  wire          CLK_SYS,
  input  wire          ARST_N,
  input  wire          WARM_RST_N,
  input  wire [AW-1:0] AVS_ADDRESS,
  input  wire          AVS_READ,
  input  wire          AVS_WRITE,
  input  wire [31:0]   AVS_WRITEDATA,
  input  wire [3:0]    AVS_BYTEENABLE,
  output reg  [31:0]   AVS_READDATA,
  output wire          AVS_WAITREQUEST,
  input  wire [19:0]   ERR_EVT,
  input  wire          ADV_NF_EVT,
  input  wire [19:0]   UNCORRECTABLE_SEVERITY_SELECT,
  output reg  [2:0]    ERR_PIN,
  output reg           MACHINE_CHECK_OUTPUT
);

  localparam N = `PEL_NUM_EVT;
  localparam [7*N-1:0] MSK_POS = `PEL_MSK_POS;
  localparam [5*N-1:0] FAT_POS = `PEL_FAT_POS;
  localparam [5*N-1:0] NFC_POS = `PEL_NFC_POS;
  localparam [2*N-1:0] CLS_TAB = `PEL_CLASS;
  // reset timeout mask bit exists only on the host-interface port
  localparam [31:0] UNC_WMASK = (HOST_PORT != 0) ?
    (`PEL_UNC_WMASK | `PEL_UNC_HOST_BIT) : `PEL_UNC_WMASK;

  // ********************************************************************
  // warm reset synchroniser
  // ********************************************************************
  reg warm_meta_reg;
  reg warm_sync_reg;

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      warm_meta_reg <= 1'b0;
      warm_sync_reg <= 1'b0;
    end else begin
      warm_meta_reg <= WARM_RST_N;
      warm_sync_reg <= warm_meta_reg;
    end
  end

  wire warm_rst;
  assign warm_rst = ~warm_sync_reg;

  // ********************************************************************
  // bus slave: one wait state, then the access completes
  // ********************************************************************
  reg         ack_reg;
  wire        req;
  wire        acc;
  wire        wr_acc;
  wire [31:0] be_mask;
  wire [31:0] wdata_be;
  wire [31:0] steer_wd;

  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign acc             = req & ack_reg;
  assign wr_acc          = AVS_WRITE & ack_reg;
  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wdata_be = AVS_WRITEDATA & be_mask;
  assign steer_wd = AVS_WRITEDATA & `PEL_STEER_WMASK;

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // zero-extend first so any address width slices cleanly to 12 bits
  wire [AW+11:0] addr_ext;
  wire [11:0]    addr_w;
  assign addr_ext = {12'h000, AVS_ADDRESS};
  assign addr_w   = addr_ext[11:0] & 12'hffc;

  wire hit_steer;
  wire hit_unc;
  wire hit_cor;
  wire hit_rp;
  wire hit_ffat;
  wire hit_fnfc;
  wire hit_nfat;

  assign hit_steer = (addr_w == `PEL_OFS_STEER);
  assign hit_unc   = (addr_w == `PEL_OFS_UNC_MSK);
  assign hit_cor   = (addr_w == `PEL_OFS_COR_MSK);
  assign hit_rp    = (addr_w == `PEL_OFS_RP_MSK);
  assign hit_ffat  = (addr_w == `PEL_OFS_FST_FAT);
  assign hit_fnfc  = (addr_w == `PEL_OFS_FST_NFC);
  assign hit_nfat  = (addr_w == `PEL_OFS_NXT_FAT);

  // ********************************************************************
  // mask and steering registers, cleared by cold or warm reset
  // ********************************************************************
  reg [31:0] unc_mask_reg;
  reg [31:0] cor_mask_reg;
  reg [31:0] rp_mask_reg;
  reg [7:0]  steer_reg;

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      unc_mask_reg <= `PEL_MASK_RST;
      cor_mask_reg <= `PEL_MASK_RST;
      rp_mask_reg  <= `PEL_MASK_RST;
      steer_reg    <= `PEL_STEER_RST;
    end else if (warm_rst) begin
      unc_mask_reg <= `PEL_MASK_RST;
      cor_mask_reg <= `PEL_MASK_RST;
      rp_mask_reg  <= `PEL_MASK_RST;
      steer_reg    <= `PEL_STEER_RST;
    end else if (wr_acc) begin
      if (hit_unc) begin
        unc_mask_reg <= ((unc_mask_reg & ~be_mask) | wdata_be)
                        & UNC_WMASK; // RULE2 RULE3 RULE4
      end
      if (hit_cor) begin
        cor_mask_reg <= ((cor_mask_reg & ~be_mask) | wdata_be)
                        & `PEL_COR_WMASK; // RULE5
      end
      if (hit_rp) begin
        rp_mask_reg <= ((rp_mask_reg & ~be_mask) | wdata_be)
                       & `PEL_RP_WMASK; // RULE6
      end
      if (hit_steer && AVS_BYTEENABLE[0]) begin
        steer_reg <= steer_wd[7:0];
      end
    end
  end

  // ********************************************************************
  // per event qualification
  // ********************************************************************
  wire [127:0] mask_all;
  wire [N-1:0] evt_hit;
  wire [N-1:0] evt_fat;
  wire [N-1:0] evt_cor;

  assign mask_all = {32'h0000_0000, rp_mask_reg, cor_mask_reg, unc_mask_reg};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_evt
      wire [6:0] mpos;
      wire [1:0] cls;
      wire       present;
      assign mpos = MSK_POS[7*gi +: 7];
      assign cls  = CLS_TAB[2*gi +: 2];
      // the reset timeout only exists on the host-interface port
      assign present = (gi != `PEL_EVT_HRST) || (HOST_PORT != 0);
      // masked errors stop here, before reporting and logging
      assign evt_hit[gi] = ERR_EVT[gi] & ~mask_all[mpos] & present; // RULE1
      assign evt_fat[gi] = (cls == `PEL_CLS_FAT) ||
        ((cls == `PEL_CLS_SEV) && UNCORRECTABLE_SEVERITY_SELECT[gi]); // RULE11
      assign evt_cor[gi] = (cls == `PEL_CLS_COR);
    end
  endgenerate

  // ********************************************************************
  // scatter events onto the log layouts
  // ********************************************************************
  reg [31:0] fat_set;
  reg [31:0] nfc_set;
  reg [4:0]  fpos;
  reg [4:0]  npos;
  integer    i;

  always @* begin
    fat_set = 32'h0000_0000;
    nfc_set = 32'h0000_0000;
    fpos    = 5'h00;
    npos    = 5'h00;
    for (i = 0; i < N; i = i + 1) begin
      fpos = FAT_POS[5*i +: 5];
      npos = NFC_POS[5*i +: 5];
      if (evt_hit[i] && evt_fat[i] && (fpos != `PEL_POS_NONE)) begin
        fat_set[fpos] = 1'b1; // RULE12 RULE13 RULE14
      end
      // advisory errors carry no non-fatal position and are skipped
      if (evt_hit[i] && !evt_fat[i] && (npos != `PEL_POS_NONE)) begin
        nfc_set[npos] = 1'b1; // RULE15 RULE16 RULE17
      end
    end
  end

  // ********************************************************************
  // first and next logs
  // ********************************************************************
  wire [31:0] fst_fat;
  wire [31:0] fst_nfc;
  wire [31:0] nxt_fat;
  wire        fst_fat_empty;
  wire        fst_nfc_empty;

  assign fst_fat_empty = ~|fst_fat;
  assign fst_nfc_empty = ~|fst_nfc;

  pel_errlog #(
    .W     (32),
    .LMASK (`PEL_FAT_LOGMASK)
  ) u_fst_fat (
    .clk      (CLK_SYS),
    .arst_n   (ARST_N),
    .cap_en   (fst_fat_empty), // RULE7
    .set_vec  (fat_set),
    .clr_we   (wr_acc & hit_ffat),
    .clr_data (wdata_be),
    .log_reg  (fst_fat)
  );

  pel_errlog #(
    .W     (32),
    .LMASK (`PEL_FAT_LOGMASK)
  ) u_nxt_fat (
    .clk      (CLK_SYS),
    .arst_n   (ARST_N),
    .cap_en   (~fst_fat_empty), // RULE9 RULE10
    .set_vec  (fat_set),
    .clr_we   (wr_acc & hit_nfat),
    .clr_data (wdata_be),
    .log_reg  (nxt_fat)
  );

  pel_errlog #(
    .W     (32),
    .LMASK (`PEL_NFC_LOGMASK)
  ) u_fst_nfc (
    .clk      (CLK_SYS),
    .arst_n   (ARST_N),
    .cap_en   (fst_nfc_empty), // RULE8
    .set_vec  (nfc_set),
    .clr_we   (wr_acc & hit_fnfc),
    .clr_data (wdata_be),
    .log_reg  (fst_nfc)
  );

  // ********************************************************************
  // read data, registered one cycle before the access completes
  // ********************************************************************
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_steer) begin
      rd_mux = {24'h00_0000, steer_reg};
    end else if (hit_unc) begin
      rd_mux = unc_mask_reg;
    end else if (hit_cor) begin
      rd_mux = cor_mask_reg;
    end else if (hit_rp) begin
      rd_mux = rp_mask_reg;
    end else if (hit_ffat) begin
      rd_mux = fst_fat;
    end else if (hit_fnfc) begin
      rd_mux = fst_nfc;
    end else if (hit_nfat) begin
      rd_mux = nxt_fat;
    end
  end

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack_reg) begin
      AVS_READDATA <= rd_mux;
    end
  end

  // ********************************************************************
  // report steering
  // ********************************************************************
  wire       rep_fat;
  wire       rep_nf;
  wire       rep_cor;
  wire       adv_hit;
  reg  [3:0] route;
  reg  [1:0] code;

  // advisory errors are reported even where the log ignores them
  assign adv_hit = ADV_NF_EVT & ~cor_mask_reg[`PEL_COR_ADV_BIT];
  assign rep_fat = |(evt_hit & evt_fat); // RULE18
  assign rep_nf  = |(evt_hit & ~evt_fat & ~evt_cor); // RULE18
  assign rep_cor = |(evt_hit & evt_cor) | adv_hit;

  always @* begin
    route = 4'h0;
    code  = steer_reg[`PEL_STEER_FAT_LSB +: 2];
    if (rep_fat) begin
      route[code] = 1'b1; // RULE20
    end
    code = steer_reg[`PEL_STEER_NF_LSB +: 2];
    if (rep_nf) begin
      route[code] = 1'b1; // RULE20
    end
    code = steer_reg[`PEL_STEER_COR_LSB +: 2];
    if (rep_cor) begin
      route[code] = 1'b1; // RULE20
    end
  end

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ERR_PIN              <= 3'h0;
      MACHINE_CHECK_OUTPUT <= 1'b0;
    end else begin
      ERR_PIN              <= route[2:0];
      MACHINE_CHECK_OUTPUT <= route[`PEL_STEER_MCHK];
    end
  end

endmodule

`default_nettype wire

// file: design/pel_regs.vh
// register offsets, field layouts and event tables of the error mask/log bank
`ifndef PEL_REGS_VH
`define PEL_REGS_VH

// ********************************************************************
// register byte offsets
// ********************************************************************
`define PEL_OFS_STEER    12'h144
`define PEL_OFS_UNC_MSK  12'h148
`define PEL_OFS_COR_MSK  12'h14c
`define PEL_OFS_RP_MSK   12'h150
`define PEL_OFS_FST_FAT  12'h154
`define PEL_OFS_FST_NFC  12'h158
`define PEL_OFS_NXT_FAT  12'h15c

// ********************************************************************
// writable / implemented bits and reset values
// ********************************************************************
`define PEL_UNC_WMASK    32'h0017_f031
`define PEL_UNC_HOST_BIT 32'h0020_0000
`define PEL_COR_WMASK    32'h0000_31c1
`define PEL_COR_ADV_BIT  5'h0d
`define PEL_RP_WMASK     32'h0000_0007
`define PEL_STEER_WMASK  32'h0000_00ff
`define PEL_FAT_LOGMASK  32'h0000_1fff
`define PEL_NFC_LOGMASK  32'h0003_ff35
`define PEL_MASK_RST     32'h0000_0000
`define PEL_STEER_RST    8'h00
`define PEL_LOG_RST      32'h0000_0000

// ********************************************************************
// steering fields and codes
// ********************************************************************
`define PEL_STEER_FAT_LSB 3'h6
`define PEL_STEER_NF_LSB  3'h4
`define PEL_STEER_COR_LSB 3'h2
`define PEL_STEER_MCHK    2'h3

// ********************************************************************
// per event tables, event 19 leftmost, event 0 rightmost
// ********************************************************************
`define PEL_NUM_EVT 20
// mask bit: 0..31 uncorrectable, 32..63 correctable, 64..95 root message
`define PEL_MSK_POS {7'h05,7'h15,7'h40,7'h2c,7'h28,7'h27,7'h26,7'h20,\
7'h41,7'h11,7'h12,7'h10,7'h0f,7'h0e,7'h0d,7'h0c,7'h00,7'h14,7'h42,7'h04}
// first/next fatal log bit, 5'h1f means not logged
`define PEL_FAT_POS {5'h0c,5'h0b,5'h1f,5'h1f,5'h1f,5'h1f,5'h1f,5'h1f,\
5'h1f,5'h09,5'h0a,5'h08,5'h07,5'h06,5'h05,5'h04,5'h03,5'h02,5'h01,5'h00}
// non-fatal/correctable log bit, 5'h1f means not logged
`define PEL_NFC_POS {5'h11,5'h1f,5'h10,5'h0f,5'h0e,5'h0d,5'h0c,5'h0b,\
5'h0a,5'h09,5'h08,5'h1f,5'h1f,5'h05,5'h04,5'h1f,5'h02,5'h1f,5'h1f,5'h00}
// class: 0 severity selected, 1 fatal, 2 non-fatal, 3 correctable
`define PEL_CLASS {2'h0,2'h0,2'h3,2'h3,2'h3,2'h3,2'h3,2'h3,2'h2,2'h0,\
2'h0,2'h0,2'h0,2'h0,2'h0,2'h0,2'h0,2'h0,2'h1,2'h0}
`define PEL_CLS_SEV   2'h0
`define PEL_CLS_FAT   2'h1
`define PEL_CLS_COR   2'h3
`define PEL_POS_NONE  5'h1f
`define PEL_EVT_HRST  5'h12

`endif

// file: design/pel_errlog.v
// sticky error log word with capture enable and write-one-to-clear
`timescale 1ns/1ps
`default_nettype none

module pel_errlog #(
  parameter        W     = 32,
  parameter [31:0] LMASK = 32'hffff_ffff
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire         cap_en,
  input  wire [W-1:0] set_vec,
  input  wire         clr_we,
  input  wire [W-1:0] clr_data,
  output reg  [W-1:0] log_reg
);

  wire [W-1:0] clr_bits;
  wire [W-1:0] set_bits;
  wire [W-1:0] log_next;

  assign clr_bits = clr_we ? clr_data : {W{1'b0}};
  assign set_bits = cap_en ? set_vec : {W{1'b0}};
  // set beats a same-cycle clear so no event is lost
  assign log_next = ((log_reg & ~clr_bits) | set_bits) & LMASK[W-1:0];

  // ********************************************************************
  // cold reset only: warm reset leaves the log untouched
  // ********************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      log_reg <= {W{1'b0}}; // RULE21
    end else begin
      log_reg <= log_next; // RULE21
    end
  end

endmodule

`default_nettype wire

// file: dv/pel_asserts.sv
// port-level assertion checker for the error mask/log bank
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// bus handshake and report pulse checks
// ****************************************************************
module pel_asserts (
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [31:0] AVS_READDATA,
  input wire logic [19:0] ERR_EVT,
  input wire logic        ADV_NF_EVT,
  input wire logic [2:0]  ERR_PIN,
  input wire logic        MACHINE_CHECK_OUTPUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  wire logic ev  = (|ERR_EVT) | ADV_NF_EVT;
  wire logic rep = (|ERR_PIN) | MACHINE_CHECK_OUTPUT;
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_lone;
    !ev ##1 ev ##1 !ev;
  endsequence
  a_wait_rd_first: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST)
    else $error("read taken without a wait cycle");
  a_wait_wr_first: assert property ($rose(AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("write taken without a wait cycle");
  a_wait_one: assert property (s_req |=> !AVS_WAITREQUEST)
    else $error("wait lasted more than one cycle");
  a_idle_nowait: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("wait raised with no request");
  a_rdata_hold: assert property (!$past(AVS_READ) |-> $stable(AVS_READDATA))
    else $error("read data moved without a read");
  a_report_cause: assert property (rep |-> $past(ev))
    else $error("report pulse without an event");
  a_lone_pulse: assert property (s_lone |=> !rep)
    else $error("report pulse longer than its event");
  a_quiet_report: assert property (!ev |=> !rep)
    else $error("report while events are quiet");
endmodule
bind pel_top pel_asserts i_pel_asserts (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_READDATA(AVS_READDATA), .ERR_EVT(ERR_EVT),
  .ADV_NF_EVT(ADV_NF_EVT), .ERR_PIN(ERR_PIN),
  .MACHINE_CHECK_OUTPUT(MACHINE_CHECK_OUTPUT));
`default_nettype wire

// file: dv/pel_err_src.sv
// error event source standing in for the port's detection logic
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// event pulses and severity levels
// ****************************************************************
module pel_err_src (
  input  wire logic        clk,
  output var  logic [19:0] err_evt,
  output var  logic        adv_evt,
  output var  logic [19:0] sev
);
  initial begin
    err_evt = 20'h0_0000;
    adv_evt = 1'b0;
    sev     = 20'h0_0000;
  end
  task automatic set_sev(input logic [19:0] s);
    @(posedge clk);
    sev <= s;
  endtask
  // one-cycle pulses only: a held bit would count every cycle
  // training index 3 is a plain event here, status lives elsewhere
  task automatic pulse(input logic [19:0] v, input logic a);
    @(posedge clk);
    err_evt <= v;
    adv_evt <= a;
    @(posedge clk);
    err_evt <= 20'h0_0000;
    adv_evt <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/pel_top_tb.sv
// self-checking bench for the error mask/log bank
`timescale 1ns/1ps
`default_nettype none
`include "pel_regs.vh"
// ****************************************************************
// bench
// ****************************************************************
module pel_top_tb;
  localparam logic [99:0] FP = `PEL_FAT_POS;
  localparam logic [99:0] NP = `PEL_NFC_POS;
  localparam logic [39:0] CL = `PEL_CLASS;
  logic        clk, arst_n, warm_n, rd, wr, wq, mco, adv;
  logic [11:0] adr;
  logic [31:0] wd, q;
  logic [19:0] evt, sev;
  logic [2:0]  pin;
  logic [3:0]  be;
  int          mismatches   = 0;
  int          total_checks = 0;

  pel_err_src i_pel_err_src (.clk(clk), .err_evt(evt), .adv_evt(adv),
    .sev(sev));
  pel_top #(.HOST_PORT(1)) i_pel_top (.CLK_SYS(clk), .ARST_N(arst_n),
    .WARM_RST_N(warm_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
    .AVS_READDATA(q), .AVS_WAITREQUEST(wq), .ERR_EVT(evt),
    .ADV_NF_EVT(adv), .UNCORRECTABLE_SEVERITY_SELECT(sev),
    .ERR_PIN(pin), .MACHINE_CHECK_OUTPUT(mco));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // the request stands until the edge where wait is seen low
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    r = q;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check($sformatf("reg %h", a), r, e);
  endtask
  task automatic rep(input logic [3:0] e);
    #1;
    check("report", {28'h0, mco, pin}, {28'h0, e});
  endtask
  function automatic logic [3:0] route(input logic [1:0] c);
    route = (c == 2'h3) ? 4'h8 : (4'h1 << c);
  endfunction
  function automatic logic [31:0] bit_of(input logic [4:0] p);
    bit_of = (p == 5'h1f) ? 32'h0 : (32'h1 << p);
  endfunction

  task automatic t_regs();
    logic [11:0] a;
    for (a = 12'h144; a <= 12'h15c; a += 12'h004) rc(a, 32'h0);
    rc(12'h100, 32'h0);
    wrr(12'h148, 32'hffff_ffff);
    rc(12'h148, 32'h0037_f031);
    be <= 4'h1;
    wrr(12'h148, 32'h0);
    be <= 4'hf;
    rc(12'h148, 32'h0037_f000);
    wrr(12'h14c, 32'hffff_ffff);
    rc(12'h14c, 32'h0000_31c1);
    wrr(12'h150, 32'hffff_ffff);
    rc(12'h150, 32'h0000_0007);
    wrr(12'h100, 32'hffff_ffff);
    rc(12'h100, 32'h0);
    for (a = 12'h148; a <= 12'h150; a += 12'h004) wrr(a, 32'h0);
    $display("test regs done");
  endtask
  // every event alone, logs cleared between, severity all one way
  task automatic t_events(input logic s, input logic [31:0] st);
    int         i;
    logic [1:0] c;
    logic       f;
    i_pel_err_src.set_sev({20{s}});
    wrr(12'h144, st);
    rc(12'h144, st);
    for (i = 0; i < 20; i++) begin
      c = CL[i*2 +: 2];
      f = (c == 2'h1) || (c == 2'h0 && s);
      i_pel_err_src.pulse(20'h1 << i, 1'b0);
      rep(route(f ? st[7:6] : (c == 2'h3 ? st[3:2] : st[5:4])));
      rc(12'h154, f ? bit_of(FP[i*5 +: 5]) : 32'h0);
      rc(12'h158, f ? 32'h0 : bit_of(NP[i*5 +: 5]));
      rc(12'h15c, 32'h0);
      wrr(12'h154, 32'hffff_ffff);
      wrr(12'h158, 32'hffff_ffff);
    end
    $display("test events done");
  endtask
  task automatic t_lock();
    i_pel_err_src.set_sev(20'hf_ffff);
    i_pel_err_src.pulse(20'h0_0200, 1'b0);
    i_pel_err_src.pulse(20'h8_0400, 1'b0);
    i_pel_err_src.pulse(20'h0_1000, 1'b0);
    i_pel_err_src.pulse(20'h0_2000, 1'b0);
    rc(12'h154, 32'h0000_0400);
    rc(12'h15c, 32'h0000_1200);
    rc(12'h158, 32'h0000_0800);
    $display("test lock done");
  endtask
  task automatic t_mask();
    wrr(12'h148, 32'h0004_0000);
    wrr(12'h150, 32'h0000_0004);
    wrr(12'h14c, 32'h0000_2000);
    i_pel_err_src.pulse(20'h0_0202, 1'b1);
    rep(4'h0);
    rc(12'h15c, 32'h0000_1200);
    $display("test mask done");
  endtask
  // warm reset keeps logs, clears masks; cold reset clears logs
  task automatic t_warm();
    @(posedge clk);
    warm_n <= 1'b0;
    repeat (4) @(posedge clk);
    warm_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(12'h14c, 32'h0);
    rc(12'h154, 32'h0000_0400);
    wrr(12'h158, 32'hffff_ffff);
    i_pel_err_src.pulse(20'h0_0000, 1'b1);
    rep(4'h1);
    rc(12'h158, 32'h0);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(12'h154, 32'h0);
    $display("test warm done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
  initial begin
    arst_n = 1'b0;
    warm_n = 1'b1;
    rd     = 1'b0;
    wr     = 1'b0;
    adr    = 12'h000;
    wd     = 32'h0;
    be     = 4'hf;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_events(1'b1, 32'h0000_00d8);
    t_events(1'b0, 32'h0000_0024);
    t_lock();
    t_mask();
    t_warm();
    finish_test();
  end
endmodule
`default_nettype wire
